/* rtl/wbgain_pkg.sv */
// constants shared by the white balance and gain controller
package wbgain_pkg;
  // register byte addresses on the camera register space
  localparam logic [31:0] GAIN_ADDR = 32'hF0F00820;
  localparam logic [31:0] WB_ADDR = 32'hF0F0080C;
  localparam logic [31:0] AE_ADDR = 32'hF0F00804;
  localparam logic [31:0] GLIM_ADDR = 32'hF1000370;
  localparam logic [31:0] GABS_ADDR = 32'hF0F00928;
  localparam logic [31:0] AOI_CTRL_ADDR = 32'hF1000390;
  localparam logic [31:0] AOI_POS_ADDR = 32'hF1000394;
  localparam logic [31:0] AOI_SIZE_ADDR = 32'hF1000398;
  // bit 0 of the feature registers is the msb of the word
  localparam int PRES_BIT = 31;
  localparam int ABS_BIT = 30;
  localparam int SHOW_BIT = 27;
  localparam int ONEPUSH_BIT = 26;
  localparam int ONOFF_BIT = 25;
  localparam int MODE_BIT = 24;
  localparam int VAL_LSB = 0;
  localparam int UB_LSB = 12;
  localparam int HI_LSB = 16;
  localparam int FW = 12;
  localparam int PIX_W = 8;
  // reset values and the field maximum
  localparam logic [11:0] GAIN_MIN_RST = 12'h000;
  localparam logic [11:0] GAIN_MAX_RST = 12'h2A8;
  localparam logic [11:0] AE_TARGET_RST = 12'h080;
  localparam logic [11:0] WB_RST = 12'h100;
  localparam logic [11:0] FW_MAX = 12'hFFF;
  // sequence and loop constants
  localparam logic [3:0] WB_FRAMES = 4'h8;
  localparam int KP_SH = 2;
  localparam int KI_SH = 4;
  localparam logic signed [15:0] ERR_LIM = 16'sh07FF;
  // trigger pause before continuous balance gives up
  localparam longint TIMEOUT_S = 10;
  localparam longint CLK_HZ = 125000000;
  localparam logic [31:0] TIMEOUT_CYC = 32'(TIMEOUT_S * CLK_HZ);
  typedef enum logic [1:0] {OP_IDLE, OP_RUN} op_state_t;
endpackage

/* rtl/white_balance_gain_control.sv */
// white balance, gain loop and measurement region controller
module white_balance_gain_control
  import wbgain_pkg::*;
#(
  parameter logic [31:0] TIMEOUT_CYCLES = wbgain_pkg::TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata_q,
  output logic reg_rvalid_q,
  input wire logic frame_start,
  input wire logic frame_end,
  input wire logic pix_valid,
  input wire logic [wbgain_pkg::FW-1:0] pix_x,
  input wire logic [wbgain_pkg::FW-1:0] pix_y,
  input wire logic [wbgain_pkg::PIX_W-1:0] pix_r,
  input wire logic [wbgain_pkg::PIX_W-1:0] pix_g,
  input wire logic [wbgain_pkg::PIX_W-1:0] pix_b,
  input wire logic [wbgain_pkg::FW-1:0] act_w,
  input wire logic [wbgain_pkg::FW-1:0] act_h,
  input wire logic stream_transmit_enable,
  input wire logic ext_trigger_mode,
  output logic [wbgain_pkg::FW-1:0] gain_q,
  output logic [wbgain_pkg::FW-1:0] wb_ub_q,
  output logic [wbgain_pkg::FW-1:0] wb_vr_q,
  output logic capture_run_q,
  output logic capture_restart_q,
  output logic stream_send_q,
  output logic overlay_q
);
  import wbgain_pkg::*;

  function automatic logic [5:0] msb_idx(input logic [31:0] v);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 0; i < 32; i++) begin
      if (v[i]) r = 6'(i);
    end
    return r;
  endfunction

  // one step per frame toward the green sum keeps the loop free of overshoot
  function automatic logic [11:0] wb_step(input logic [11:0] cur,
                                          input logic [39:0] chan,
                                          input logic [39:0] ref_g);
    logic [11:0] r;
    r = cur;
    if (chan < ref_g && cur != FW_MAX) r = cur + 12'h001;
    else if (chan > ref_g && cur != 12'h000) r = cur - 12'h001;
    return r;
  endfunction

  // ---- region and statistics state ----
  logic [11:0] x0, y0, x1, y1, w4, h4;
  logic aoi_ok, in_area, on_edge;
  logic [39:0] sr_q, sr_d, sg_q, sg_d, sb_q, sb_d;
  logic [31:0] cnt_q, cnt_d, st_cnt_q, st_cnt_d;
  logic [39:0] st_r_q, st_r_d, st_g_q, st_g_d, st_b_q, st_b_d;
  logic stv_q, stv_d, ovl_d;
  // ---- control state ----
  op_state_t op_q, op_d;
  logic [3:0] frames_q, frames_d;
  logic cap_saved_q, cap_saved_d, restart_d;
  logic gain_on_q, gain_on_d, gain_auto_q, gain_auto_d, gain_abs_q, gain_abs_d;
  logic [11:0] gain_val_q, gain_val_d, gabs_q, gabs_d, gout_d;
  logic [11:0] gmin_q, gmin_d, gmax_q, gmax_d, target_q, target_d;
  logic wb_on_q, wb_on_d, wb_auto_q, wb_auto_d, wb_abs_q, wb_abs_d;
  logic [11:0] ub_q, ub_d, vr_q, vr_d;
  logic aoi_on_q, aoi_on_d, aoi_show_q, aoi_show_d;
  logic [11:0] ax_q, ax_d, ay_q, ay_d, aw_q, aw_d, ah_q, ah_d;
  logic [31:0] tmo_q, tmo_d, rdata_d;
  logic rvalid_d;
  logic signed [15:0] eprev_q, eprev_d;
  logic signed [47:0] err_w, err_sh;
  logic signed [15:0] e_c, dlt, g_new;

  // region shared by auto gain and continuous balance, apart from the output window; one-shot balance ignores it
  always_comb begin
    w4 = (aw_q + 12'h003) & 12'hFFC;
    h4 = (ah_q + 12'h003) & 12'hFFC;
    aoi_ok = (w4 != 12'h000) && (h4 != 12'h000) &&
             (ax_q < act_w) && (ay_q < act_h);
    if (aoi_on_q && op_q != OP_RUN) begin
      x0 = ax_q;
      y0 = ay_q;
      x1 = ax_q + w4;
      y1 = ay_q + h4;
    end else begin
      // one-shot balance always samples the whole image
      x0 = 12'h000;
      y0 = 12'h000;
      x1 = act_w;
      y1 = act_h;
    end
    in_area = (pix_x >= x0) && (pix_x < x1) && (pix_y >= y0) &&
              (pix_y < y1);
    on_edge = in_area && (pix_x == x0 || pix_x == x1 - 12'h001 ||
                          pix_y == y0 || pix_y == y1 - 12'h001);
  end

  always_comb begin
    sr_d = sr_q;
    sg_d = sg_q;
    sb_d = sb_q;
    cnt_d = cnt_q;
    st_r_d = st_r_q;
    st_g_d = st_g_q;
    st_b_d = st_b_q;
    st_cnt_d = st_cnt_q;
    stv_d = 1'b0;
    ovl_d = pix_valid && aoi_show_q && on_edge;
    if (frame_start) begin
      sr_d = 40'h0;
      sg_d = 40'h0;
      sb_d = 40'h0;
      cnt_d = 32'h0;
    end else if (pix_valid && in_area) begin
      sr_d = sr_q + 40'(pix_r);
      sg_d = sg_q + 40'(pix_g);
      sb_d = sb_q + 40'(pix_b);
      cnt_d = cnt_q + 32'h1;
    end
    if (frame_end) begin
      st_r_d = sr_q;
      st_g_d = sg_q;
      st_b_d = sb_q;
      st_cnt_d = cnt_q;
      stv_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sr_q <= 40'h0;
      sg_q <= 40'h0;
      sb_q <= 40'h0;
      cnt_q <= 32'h0;
      st_r_q <= 40'h0;
      st_g_q <= 40'h0;
      st_b_q <= 40'h0;
      st_cnt_q <= 32'h0;
      stv_q <= 1'b0;
      overlay_q <= 1'b0;
    end else begin
      sr_q <= sr_d;
      sg_q <= sg_d;
      sb_q <= sb_d;
      cnt_q <= cnt_d;
      st_r_q <= st_r_d;
      st_g_q <= st_g_d;
      st_b_q <= st_b_d;
      st_cnt_q <= st_cnt_d;
      stv_q <= stv_d;
      overlay_q <= ovl_d;
    end
  end

  // PI gain loop in velocity form; error is scaled to grey levels
  always_comb begin
    err_w = $signed({4'h0, 44'(target_q) * 44'(st_cnt_q)}) -
            $signed({8'h00, st_g_q});
    err_sh = err_w >>> msb_idx(st_cnt_q);
    if (err_sh > 48'(ERR_LIM)) e_c = ERR_LIM;
    else if (err_sh < -48'(ERR_LIM)) e_c = -ERR_LIM;
    else e_c = 16'(err_sh);
    dlt = ((e_c - eprev_q) >>> KP_SH) + (e_c >>> KI_SH);
    g_new = $signed({4'h0, gain_val_q}) + dlt;
    if (g_new > $signed({4'h0, gmax_q})) g_new = $signed({4'h0, gmax_q});
    if (g_new < $signed({4'h0, gmin_q})) g_new = $signed({4'h0, gmin_q});
  end

  always_comb begin
    op_d = op_q;
    frames_d = frames_q;
    cap_saved_d = cap_saved_q;
    restart_d = 1'b0;
    gain_on_d = gain_on_q;
    gain_auto_d = gain_auto_q;
    gain_abs_d = gain_abs_q;
    gain_val_d = gain_val_q;
    gabs_d = gabs_q;
    gmin_d = gmin_q;
    gmax_d = gmax_q;
    target_d = target_q;
    wb_on_d = wb_on_q;
    wb_auto_d = wb_auto_q;
    wb_abs_d = wb_abs_q;
    ub_d = ub_q;
    vr_d = vr_q;
    aoi_on_d = aoi_on_q;
    aoi_show_d = aoi_show_q;
    ax_d = ax_q;
    ay_d = ay_q;
    aw_d = aw_q;
    ah_d = ah_q;
    eprev_d = eprev_q;
    rvalid_d = 1'b0;
    rdata_d = reg_rdata_q;
    // pause counter runs regardless of capture state
    if (wb_on_q && wb_auto_q && ext_trigger_mode && !stv_q)
      tmo_d = tmo_q + 32'h1;
    else
      tmo_d = 32'h0;
    if (tmo_q >= TIMEOUT_CYCLES) begin
      wb_auto_d = 1'b0;
      tmo_d = 32'h0;
    end
    if (stv_q) begin
      if (op_q == OP_RUN) begin
        ub_d = wb_step(ub_q, st_b_q, st_g_q);
        vr_d = wb_step(vr_q, st_r_q, st_g_q);
        frames_d = frames_q + 4'h1;
        if (frames_q == WB_FRAMES - 4'h1) begin
          op_d = OP_IDLE;
          frames_d = 4'h0;
          restart_d = cap_saved_q;
        end
      end else if (wb_on_q && wb_auto_q) begin
        ub_d = wb_step(ub_q, st_b_q, st_g_q);
        vr_d = wb_step(vr_q, st_r_q, st_g_q);
      end
      if (gain_on_q && gain_auto_q) begin
        gain_val_d = 12'(g_new);
        eprev_d = e_c;
      end
    end
    if (aoi_on_q && !aoi_ok) aoi_on_d = 1'b0;
    if (reg_wr) begin
      case (reg_addr)
        GAIN_ADDR: begin
          gain_on_d = reg_wdata[ONOFF_BIT];
          gain_auto_d = reg_wdata[MODE_BIT];
          gain_abs_d = reg_wdata[ABS_BIT];
          if (reg_wdata[ONOFF_BIT] && !reg_wdata[MODE_BIT])
            gain_val_d = reg_wdata[VAL_LSB +: FW];
        end
        WB_ADDR: begin
          wb_on_d = reg_wdata[ONOFF_BIT];
          wb_auto_d = reg_wdata[MODE_BIT];
          wb_abs_d = reg_wdata[ABS_BIT];
          if (!reg_wdata[MODE_BIT]) begin
            ub_d = reg_wdata[UB_LSB +: FW];
            vr_d = reg_wdata[VAL_LSB +: FW];
          end
          if (reg_wdata[ONEPUSH_BIT] && op_q == OP_IDLE) begin
            op_d = OP_RUN;
            frames_d = 4'h0;
            cap_saved_d = stream_transmit_enable;
          end
        end
        AE_ADDR: target_d = reg_wdata[VAL_LSB +: FW];
        GLIM_ADDR: begin
          gmin_d = reg_wdata[VAL_LSB +: FW];
          gmax_d = reg_wdata[HI_LSB +: FW];
        end
        GABS_ADDR: gabs_d = reg_wdata[VAL_LSB +: FW];
        AOI_CTRL_ADDR: begin
          aoi_on_d = reg_wdata[ONOFF_BIT];
          aoi_show_d = reg_wdata[SHOW_BIT];
        end
        AOI_POS_ADDR: begin
          ax_d = reg_wdata[HI_LSB +: FW];
          ay_d = reg_wdata[VAL_LSB +: FW];
        end
        AOI_SIZE_ADDR: begin
          aw_d = reg_wdata[HI_LSB +: FW];
          ah_d = reg_wdata[VAL_LSB +: FW];
        end
        default: ;
      endcase
    end
    if (reg_rd) begin
      rvalid_d = 1'b1;
      rdata_d = 32'h0;
      case (reg_addr)
        GAIN_ADDR: begin
          rdata_d[PRES_BIT] = 1'b1;
          rdata_d[ABS_BIT] = gain_abs_q;
          rdata_d[ONOFF_BIT] = gain_on_q;
          rdata_d[MODE_BIT] = gain_auto_q;
          rdata_d[VAL_LSB +: FW] = gain_val_q;
        end
        WB_ADDR: begin
          rdata_d[PRES_BIT] = 1'b1;
          rdata_d[ABS_BIT] = wb_abs_q;
          rdata_d[ONEPUSH_BIT] = (op_q == OP_RUN);
          rdata_d[ONOFF_BIT] = wb_on_q;
          rdata_d[MODE_BIT] = wb_auto_q;
          rdata_d[UB_LSB +: FW] = ub_q;
          rdata_d[VAL_LSB +: FW] = vr_q;
        end
        AE_ADDR: begin
          rdata_d[PRES_BIT] = 1'b1;
          rdata_d[VAL_LSB +: FW] = target_q;
        end
        GLIM_ADDR: begin
          rdata_d[VAL_LSB +: FW] = gmin_q;
          rdata_d[HI_LSB +: FW] = gmax_q;
        end
        GABS_ADDR: rdata_d[VAL_LSB +: FW] = gabs_q;
        AOI_CTRL_ADDR: begin
          rdata_d[ONOFF_BIT] = aoi_on_q;
          rdata_d[SHOW_BIT] = aoi_show_q;
        end
        AOI_POS_ADDR: rdata_d = {4'h0, ax_q, 4'h0, ay_q};
        AOI_SIZE_ADDR: rdata_d = {4'h0, aw_q, 4'h0, ah_q};
        default: rdata_d = 32'h0;
      endcase
    end
    // gain path has no offset term, so black level is untouched
    if (!gain_on_d) gout_d = gmin_d;
    else if (gain_abs_d && !gain_auto_d) gout_d = gabs_d;
    else gout_d = gain_val_d;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      op_q <= OP_IDLE;
      frames_q <= 4'h0;
      cap_saved_q <= 1'b0;
      capture_restart_q <= 1'b0;
      gain_on_q <= 1'b1;
      gain_auto_q <= 1'b0;
      gain_abs_q <= 1'b0;
      gain_val_q <= GAIN_MIN_RST;
      gabs_q <= GAIN_MIN_RST;
      gmin_q <= GAIN_MIN_RST;
      gmax_q <= GAIN_MAX_RST;
      target_q <= AE_TARGET_RST;
      wb_on_q <= 1'b1;
      wb_auto_q <= 1'b0;
      wb_abs_q <= 1'b0;
      ub_q <= WB_RST;
      vr_q <= WB_RST;
      aoi_on_q <= 1'b0;
      aoi_show_q <= 1'b0;
      ax_q <= 12'h000;
      ay_q <= 12'h000;
      aw_q <= 12'h000;
      ah_q <= 12'h000;
      eprev_q <= 16'sh0000;
      tmo_q <= 32'h0;
      reg_rdata_q <= 32'h0;
      reg_rvalid_q <= 1'b0;
      gain_q <= GAIN_MIN_RST;
      wb_ub_q <= WB_RST;
      wb_vr_q <= WB_RST;
      capture_run_q <= 1'b0;
      stream_send_q <= 1'b0;
    end else begin
      op_q <= op_d;
      frames_q <= frames_d;
      cap_saved_q <= cap_saved_d;
      capture_restart_q <= restart_d;
      gain_on_q <= gain_on_d;
      gain_auto_q <= gain_auto_d;
      gain_abs_q <= gain_abs_d;
      gain_val_q <= gain_val_d;
      gabs_q <= gabs_d;
      gmin_q <= gmin_d;
      gmax_q <= gmax_d;
      target_q <= target_d;
      wb_on_q <= wb_on_d;
      wb_auto_q <= wb_auto_d;
      wb_abs_q <= wb_abs_d;
      ub_q <= ub_d;
      vr_q <= vr_d;
      aoi_on_q <= aoi_on_d;
      aoi_show_q <= aoi_show_d;
      ax_q <= ax_d;
      ay_q <= ay_d;
      aw_q <= aw_d;
      ah_q <= ah_d;
      eprev_q <= eprev_d;
      tmo_q <= tmo_d;
      reg_rdata_q <= rdata_d;
      reg_rvalid_q <= rvalid_d;
      gain_q <= gout_d;
      wb_ub_q <= ub_d;
      wb_vr_q <= vr_d;
      capture_run_q <= (op_d == OP_RUN) || stream_transmit_enable;
      stream_send_q <= stream_transmit_enable;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_busy_readback: assert property (reg_rd && reg_addr == WB_ADDR |=>
    reg_rdata_q[ONEPUSH_BIT] == ($past(op_q) == OP_RUN))
    else $error("one-shot busy bit wrong on readback");
  a_eight_frames: assert property ($fell(op_q == OP_RUN) |->
    $past(frames_q) == 4'h7 && $past(stv_q))
    else $error("one-shot balance ended before eight frames");
  a_restart_pulse: assert property ($fell(op_q == OP_RUN) &&
    $past(cap_saved_q) |-> capture_restart_q)
    else $error("capture not restarted after one-shot balance");
  a_gain_limits: assert property (stv_q && gain_on_q && gain_auto_q &&
    !reg_wr && gmin_q <= gmax_q |=> gain_val_q >= gmin_q &&
    gain_val_q <= gmax_q)
    else $error("auto gain left its limits");
  a_gain_ignore: assert property (reg_wr && reg_addr == GAIN_ADDR &&
    reg_wdata[MODE_BIT] && !stv_q |=> gain_val_q == $past(gain_val_q))
    else $error("gain value written in auto mode");
  a_awb_timeout: assert property (tmo_q >= TIMEOUT_CYCLES && !reg_wr
    |=> !wb_auto_q)
    else $error("continuous balance not aborted after pause");
  a_region_clear: assert property (aoi_on_q && !aoi_ok && !reg_wr
    |=> !aoi_on_q)
    else $error("invalid region left switched on");
  a_abs_select: assert property (gain_on_q && gain_abs_q &&
    !gain_auto_q && !reg_wr |=> gain_q == $past(gabs_q))
    else $error("absolute gain not applied");
  a_overlay_off: assert property (!aoi_show_q |=> !overlay_q)
    else $error("overlay shown with show bit low");
  c_onepush_done: cover property ($fell(op_q == OP_RUN));
  c_awb_abort: cover property ($fell(wb_auto_q) && !$past(reg_wr));
  c_gain_step: cover property (stv_q && gain_auto_q ##1
    gain_val_q != $past(gain_val_q));
endmodule

/* tb/host_model.sv */
// host side model: single-word register writes and reads
module host_model (
  input wire logic clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [31:0] reg_addr,
  output logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata_q,
  input wire logic reg_rvalid_q
);
  timeunit 1ns;
  timeprecision 1ps;

  logic rd_lost = 1'b0;

  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 32'h00000000;
    reg_wdata = 32'h00000000;
  end

  // released lines carry the inverse so a stale value never passes
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    #1;
  endtask

  // a read with no answer returns unknown and raises rd_lost
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    logic got;
    got = 1'b0;
    d = 32'hXXXXXXXX;
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      if (reg_rvalid_q === 1'b1) begin
        d = reg_rdata_q;
        got = 1'b1;
        break;
      end
    end
    if (!got) rd_lost = 1'b1;
  endtask
endmodule

/* tb/tb.sv */
// testbench: gain, white balance, region and overlay scenarios
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
  n_errors++; $display("Error %s expected %h seen %h", nm, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import wbgain_pkg::*;

  logic clk = 1'b0;
  logic reset, reg_wr, reg_rd, reg_rvalid_q;
  logic [31:0] reg_addr, reg_wdata, reg_rdata_q;
  logic frame_start, frame_end, pix_valid;
  logic [11:0] pix_x, pix_y, gain_q, wb_ub_q, wb_vr_q;
  logic [7:0] pix_r, pix_g, pix_b;
  logic stream_transmit_enable, ext_trigger_mode;
  logic capture_run_q, capture_restart_q, stream_send_q, overlay_q;
  int n_errors = 0;
  int compares = 0;
  int n_restart = 0;
  logic [31:0] seed = 32'h00006A65;

  white_balance_gain_control #(.TIMEOUT_CYCLES(32'h000000C8)) dut (
    .clk(clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
    .frame_start(frame_start), .frame_end(frame_end),
    .pix_valid(pix_valid), .pix_x(pix_x), .pix_y(pix_y),
    .pix_r(pix_r), .pix_g(pix_g), .pix_b(pix_b),
    .act_w(12'h004), .act_h(12'h004),
    .stream_transmit_enable(stream_transmit_enable),
    .ext_trigger_mode(ext_trigger_mode), .gain_q(gain_q),
    .wb_ub_q(wb_ub_q), .wb_vr_q(wb_vr_q), .capture_run_q(capture_run_q),
    .capture_restart_q(capture_restart_q), .stream_send_q(stream_send_q),
    .overlay_q(overlay_q));

  host_model host (
    .clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .reg_rvalid_q(reg_rvalid_q));

  always #4 clk = ~clk;

  always @(posedge clk) begin
    if (capture_restart_q === 1'b1) n_restart++;
  end

  // a read that never got its answer ends the run at once
  always @(posedge clk) begin
    if (host.rd_lost === 1'b1) begin
      n_errors++;
      end_sim();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [31:0] gw(input logic a, o, m,
                                     input logic [11:0] v);
    return {1'b1, a, 4'h0, o, m, 12'h000, v};
  endfunction

  function automatic logic [31:0] ww(input logic p, o, m,
                                     input logic [11:0] u, r);
    return {2'b10, 3'h0, p, o, m, u, r};
  endfunction

  // whole 4x4 image of one colour, then the statistics latch
  task automatic frame(input logic [7:0] r, g, b);
    @(posedge clk);
    frame_start <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      frame_start <= 1'b0;
      pix_valid <= 1'b1;
      pix_x <= 12'(i % 4);
      pix_y <= 12'(i / 4);
      {pix_r, pix_g, pix_b} <= {r, g, b};
    end
    @(posedge clk);
    pix_valid <= 1'b0;
    {pix_r, pix_g, pix_b} <= ~{r, g, b};
    frame_end <= 1'b1;
    @(posedge clk);
    frame_end <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic pixel(input logic [11:0] x, y);
    @(posedge clk);
    pix_valid <= 1'b1;
    pix_x <= x;
    pix_y <= y;
    @(posedge clk);
    pix_valid <= 1'b0;
    #1;
  endtask

  task automatic end_sim();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    end_sim();
  end

  initial begin
    logic [31:0] d, v;
    reset = 1'b1;
    {frame_start, frame_end, pix_valid} = 3'h0;
    {pix_x, pix_y, pix_r, pix_g, pix_b} = 48'h0;
    stream_transmit_enable = 1'b0;
    ext_trigger_mode = 1'b0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    host.rd(GAIN_ADDR, d);
    `CHK("gain reset", gw(0, 1, 0, 12'h000), d)
    host.rd(WB_ADDR, d);
    `CHK("wb reset", ww(0, 1, 0, WB_RST, WB_RST), d)
    host.rd(32'hF0F00824, d);
    `CHK("unmapped", 32'h00000000, d)
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      v = (i == 0) ? 32'h000002A8 : 32'(seed[11:0] % 12'h2A9);
      host.wr(GAIN_ADDR, gw(0, 1, 0, v[11:0]));
      `CHK("gain applied", v[11:0], gain_q)
      host.rd(GAIN_ADDR, d);
      `CHK("gain readback", gw(0, 1, 0, v[11:0]), d)
    end
    host.wr(GAIN_ADDR, gw(0, 1, 1, 12'h5A5));
    host.rd(GAIN_ADDR, d);
    `CHK("auto value", gw(0, 1, 1, v[11:0]), d)
    host.wr(GAIN_ADDR, gw(0, 0, 0, 12'h3C3));
    host.rd(GAIN_ADDR, d);
    `CHK("off value", gw(0, 0, 0, v[11:0]), d)
    `CHK("off gain", GAIN_MIN_RST, gain_q)
    host.wr(GABS_ADDR, 32'h00000123);
    host.wr(GAIN_ADDR, gw(1, 1, 0, 12'h045));
    `CHK("abs gain", 12'h123, gain_q)
    host.wr(GAIN_ADDR, gw(0, 1, 0, 12'h045));
    `CHK("value gain", 12'h045, gain_q)
    $display("test manual gain done");
    seed = lfsr(seed);
    host.wr(WB_ADDR, ww(0, 1, 0, seed[11:0], seed[23:12]));
    host.rd(WB_ADDR, d);
    `CHK("wb readback", ww(0, 1, 0, seed[11:0], seed[23:12]), d)
    `CHK("ub out", seed[11:0], wb_ub_q)
    `CHK("vr out", seed[23:12], wb_vr_q)
    // blue above green and red below it: each frame steps one count
    stream_transmit_enable <= 1'b1;
    host.wr(WB_ADDR, ww(0, 1, 0, WB_RST, WB_RST));
    host.wr(WB_ADDR, ww(1, 1, 0, WB_RST, WB_RST));
    `CHK("capture run", 1'b1, capture_run_q)
    host.rd(WB_ADDR, d);
    `CHK("busy", 1'b1, d[ONEPUSH_BIT])
    for (int i = 0; i < 8; i++) begin
      frame(8'h0A, 8'h14, 8'h1E);
      `CHK("stream send", 1'b1, stream_send_q)
    end
    `CHK("restart", 1, n_restart)
    host.rd(WB_ADDR, d);
    `CHK("wb result", ww(0, 1, 0, 12'h0F8, 12'h108), d)
    $display("test one-shot done");
    host.wr(GLIM_ADDR, 32'h00200010);
    host.wr(GAIN_ADDR, gw(0, 1, 1, 12'h000));
    for (int i = 0; i < 12; i++) begin
      frame(8'h00, (i < 6) ? 8'h00 : 8'hFF, 8'h00);
      `CHK("in limits", 1'b1, gain_q >= 12'h010 && gain_q <= 12'h020)
      if (i == 5) `CHK("dark at max", 12'h020, gain_q)
    end
    `CHK("bright falls", 1'b1, gain_q < 12'h020)
    $display("test auto gain done");
    host.wr(AOI_CTRL_ADDR, 32'h02000000);
    repeat (2) @(posedge clk);
    host.rd(AOI_CTRL_ADDR, d);
    `CHK("bad region", 1'b0, d[ONOFF_BIT])
    host.wr(AOI_SIZE_ADDR, 32'h00030003);
    host.wr(AOI_CTRL_ADDR, 32'h0A000000);
    host.rd(AOI_CTRL_ADDR, d);
    `CHK("good region", 1'b1, d[ONOFF_BIT])
    pixel(12'h000, 12'h000);
    `CHK("border shown", 1'b1, overlay_q)
    pixel(12'h001, 12'h001);
    `CHK("inside plain", 1'b0, overlay_q)
    pixel(12'h003, 12'h003);
    `CHK("rounded edge", 1'b1, overlay_q)
    $display("test region done");
    stream_transmit_enable <= 1'b0;
    ext_trigger_mode <= 1'b1;
    host.wr(WB_ADDR, ww(0, 1, 1, 12'h000, 12'h000));
    host.rd(WB_ADDR, d);
    `CHK("awb idle", ww(0, 1, 1, 12'h0F8, 12'h108), d)
    repeat (400) @(posedge clk);
    host.rd(WB_ADDR, d);
    `CHK("awb abort", 1'b0, d[MODE_BIT])
    $display("test trigger pause done");
    end_sim();
  end
endmodule
